// ===== design/brc_map.svh
// Purpose: offsets, field positions, codes and timing figures of the brown-out reset control
// Assumes: 200 MHz ref_clk
// Notes: definitions only
`ifndef BRC_MAP_SVH
`define BRC_MAP_SVH

`define BRC_ADDR_W 4
`define BRC_OFF_CTRL 4'h0
`define BRC_CTRL_SWEN_BIT 7
`define BRC_CTRL_RDY_BIT 0
`define BRC_CTRL_RESET 8'h80
`define BRC_RDATA_ZERO 8'h00

`define BRC_MODE_ON 2'h3
`define BRC_MODE_SLEEP_OFF 2'h2
`define BRC_MODE_SW 2'h1
`define BRC_MODE_OFF 2'h0

`define BRC_ERASE_MV 2450
`define BRC_LVL_ERASE 2'h0

`define BRC_CLK_NS 5
`define BRC_WARM_NS 2000
`define BRC_FILT_NS 1000
`define BRC_POWER_UP_TIMER_NS 10000

`define BRC_CNT_W 16
`define BRC_CNT_ZERO 16'h0000
`define BRC_CNT_ONE 16'h0001

`endif

// ===== design/brc_pkg.sv
// Purpose: types shared by the brown-out reset control
// Assumes: nothing beyond the map header
// Notes: states are one-hot
package brc_pkg;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] level;
    logic power_up_timer_en;
  } brc_cfg_t;

  typedef struct packed {
    logic external_reset_pin;
    logic watchdog;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic prog_exit;
    logic exec_violation_reset;
  } brc_rst_src_t;

  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_POWER_UP_TIMER = 6'h02,
    ST_START_WAIT = 6'h04,
    ST_RUN = 6'h08,
    ST_SLEEP = 6'h10,
    ST_WAKE_WAIT = 6'h20
  } brc_state_t;

endpackage

// ===== design/brc_reset_ctrl.sv
// Summary of operation
// - mode 11 keeps monitor on, startup waits
// - mode 11 protects in sleep, wakes immediately
// - mode 10 monitor on awake, hibernates asleep
// - mode 10 unprotected asleep, wake waits ready
// - mode 01 software enable bit governs monitor
// - mode 01 never delays startup or wake
// - mode 01 protection starts once ready
// - mode 00 monitor off, execution immediate
// - enable bit writable but ignored outside 01
// - ready status read-only at bit 0
// - enable bit 7, set by power fail
// - bulk erase forces monitor on at 2.45V
// - erase-time brown-out aborts erase, no reset
// - level select passed to the monitor
// - only dips longer than filter time reset
// - held in reset while power-on not good
// - optional power-up timer extends reset
// - any listed source asserts device reset
// - low-power and main brown-out ORed together
//
// Purpose: brown-out monitor control, start-up/wake gating and reset combining
// Assumes: inputs synchronous to ref_clk except the three analog raw levels
// Notes: register port answers one cycle after the read strobe
// Notes: other reset sources hold reset only while high and keep the enable bit
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "brc_map.svh"

module brc_reset_ctrl #(
  parameter int WARM_NS = `BRC_WARM_NS,
  parameter int FILT_NS = `BRC_FILT_NS,
  parameter int POWER_UP_TIMER_NS = `BRC_POWER_UP_TIMER_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`BRC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire brc_pkg::brc_cfg_t cfg,
  input wire brc_pkg::brc_rst_src_t rst_src,
  input wire logic por_good_raw,
  input wire logic bor_below_raw,
  input wire logic low_power_brownout_raw,
  input wire logic sleep_active,
  input wire logic bulk_erase_active,
  output logic monitor_enable,
  output logic [1:0] monitor_level,
  output logic monitor_erase_force,
  output logic erase_abort,
  output logic generic_bor_reset,
  output logic device_reset_n,
  output logic exec_enable
);

  // least times round up to whole cycles, never below one
  function automatic logic [`BRC_CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + `BRC_CLK_NS - 1) / `BRC_CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[`BRC_CNT_W-1:0];
  endfunction

  // control register address decode
  function automatic logic ctrl_hit(input logic [`BRC_ADDR_W-1:0] addr);
    return addr == `BRC_OFF_CTRL;
  endfunction

  // modes in which start-up waits for a ready monitor and a good supply
  function automatic logic start_waits(input logic [1:0] mode);
    return mode == `BRC_MODE_ON || mode == `BRC_MODE_SLEEP_OFF;
  endfunction

  // only the sleep-off mode makes wake-up wait for the monitor
  function automatic logic wake_waits(input logic [1:0] mode);
    return mode == `BRC_MODE_SLEEP_OFF;
  endfunction

  // monitor activity per mode, before the erase override
  function automatic logic mode_active(input logic [1:0] mode, input logic asleep, input logic swen);
    logic act;
    act = 1'b0;
    case (mode)
      `BRC_MODE_ON: act = 1'b1;
      `BRC_MODE_SLEEP_OFF: act = !asleep;
      `BRC_MODE_SW: act = swen;
      `BRC_MODE_OFF: act = 1'b0;
      default: act = 1'b0;
    endcase
    return act;
  endfunction

  // control word as software sees it; bits 6..1 stay zero
  function automatic logic [7:0] ctrl_word(input logic swen, input logic rdy);
    logic [7:0] w;
    w = `BRC_RDATA_ZERO;
    w[`BRC_CTRL_SWEN_BIT] = swen;
    w[`BRC_CTRL_RDY_BIT] = rdy;
    return w;
  endfunction

  // states in which the power-up sequence still holds reset
  function automatic logic holds_reset(input brc_pkg::brc_state_t st);
    return st == brc_pkg::ST_HOLD || st == brc_pkg::ST_POWER_UP_TIMER;
  endfunction

  localparam logic [`BRC_CNT_W-1:0] WARM_CYC = ns_to_cyc(WARM_NS);
  localparam logic [`BRC_CNT_W-1:0] FILT_CYC = ns_to_cyc(FILT_NS);
  localparam logic [`BRC_CNT_W-1:0] POWER_UP_TIMER_CYC = ns_to_cyc(POWER_UP_TIMER_NS);

  logic [1:0] por_sync_ff;
  logic [1:0] below_sync_ff;
  logic [1:0] lp_sync_ff;
  logic por_ok;
  logic below;
  logic lp_req;

  logic sw_en_ff;
  logic ready_ff;
  logic [`BRC_CNT_W-1:0] warm_cnt_ff;
  logic [`BRC_CNT_W-1:0] filt_cnt_ff;
  logic [`BRC_CNT_W-1:0] power_up_timer_cnt_ff;
  logic trip_ff;
  brc_pkg::brc_state_t state_ff;
  brc_pkg::brc_state_t nxt_state;

  logic mon_on;
  logic power_fail;
  logic bor_det;
  logic start_hold;
  logic other_rst;
  logic ctrl_wr;
  logic ctrl_rd;

  // two-stage synchronisers for the analog detectors
  // only the second stage is read, the first may be metastable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      por_sync_ff <= 2'h0;
      below_sync_ff <= 2'h0;
      lp_sync_ff <= 2'h0;
    end else begin
      por_sync_ff <= {por_sync_ff[0], por_good_raw};
      below_sync_ff <= {below_sync_ff[0], bor_below_raw};
      lp_sync_ff <= {lp_sync_ff[0], low_power_brownout_raw};
    end
  end

  assign por_ok = por_sync_ff[1];
  assign below = below_sync_ff[1];
  assign lp_req = lp_sync_ff[1];

  // monitor activity per mode, overridden by bulk erase
  always_comb begin
    if (bulk_erase_active) begin
      mon_on = 1'b1;
    end else begin
      mon_on = mode_active(cfg.mode, sleep_active, sw_en_ff);
    end
  end

  // warm-up before the ready status rises
  // ready drops at once on hibernation, so a stale ready never gates wake-up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      warm_cnt_ff <= `BRC_CNT_ZERO;
      ready_ff <= 1'b0;
    end else if (!mon_on) begin
      warm_cnt_ff <= `BRC_CNT_ZERO;
      ready_ff <= 1'b0;
    end else if (warm_cnt_ff >= WARM_CYC - `BRC_CNT_ONE) begin
      ready_ff <= 1'b1;
    end else begin
      warm_cnt_ff <= warm_cnt_ff + `BRC_CNT_ONE;
    end
  end

  // noise filter: a dip must outlast the filter time
  // dips only count while the monitor is armed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      filt_cnt_ff <= `BRC_CNT_ZERO;
      trip_ff <= 1'b0;
    end else if (!(ready_ff && below)) begin
      filt_cnt_ff <= `BRC_CNT_ZERO;
      trip_ff <= 1'b0;
    end else if (filt_cnt_ff >= FILT_CYC) begin
      trip_ff <= 1'b1;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + `BRC_CNT_ONE;
    end
  end

  assign bor_det = trip_ff && !bulk_erase_active;
  assign power_fail = !por_ok || bor_det || lp_req;
  assign other_rst = |rst_src;

  // start-up waits only in modes 11 and 10
  assign start_hold = start_waits(cfg.mode) && !(ready_ff && !below);

  // enable bit: set by power fail wins over a write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_en_ff <= 1'b1;
    end else if (power_fail) begin
      sw_en_ff <= 1'b1;
    end else if (ctrl_wr) begin
      sw_en_ff <= reg_wdata[`BRC_CTRL_SWEN_BIT];
    end
  end

  // power-up timer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_up_timer_cnt_ff <= `BRC_CNT_ZERO;
    end else if (state_ff == brc_pkg::ST_POWER_UP_TIMER) begin
      power_up_timer_cnt_ff <= power_up_timer_cnt_ff + `BRC_CNT_ONE;
    end else begin
      power_up_timer_cnt_ff <= `BRC_CNT_ZERO;
    end
  end

  // start-up and sleep sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      brc_pkg::ST_HOLD: begin
        if (!power_fail) begin
          if (cfg.power_up_timer_en) begin
            nxt_state = brc_pkg::ST_POWER_UP_TIMER;
          end else begin
            nxt_state = brc_pkg::ST_START_WAIT;
          end
        end
      end
      brc_pkg::ST_POWER_UP_TIMER: begin
        if (power_up_timer_cnt_ff >= POWER_UP_TIMER_CYC - `BRC_CNT_ONE) begin
          nxt_state = brc_pkg::ST_START_WAIT;
        end
      end
      brc_pkg::ST_START_WAIT: begin
        if (!start_hold) begin
          nxt_state = brc_pkg::ST_RUN;
        end
      end
      brc_pkg::ST_RUN: begin
        if (sleep_active) begin
          nxt_state = brc_pkg::ST_SLEEP;
        end
      end
      brc_pkg::ST_SLEEP: begin
        if (!sleep_active) begin
          if (wake_waits(cfg.mode)) begin
            nxt_state = brc_pkg::ST_WAKE_WAIT;
          end else begin
            nxt_state = brc_pkg::ST_RUN;
          end
        end
      end
      brc_pkg::ST_WAKE_WAIT: begin
        if (ready_ff) begin
          nxt_state = brc_pkg::ST_RUN;
        end
      end
      default: nxt_state = brc_pkg::ST_HOLD;
    endcase
    // power fail from any state restarts the whole sequence
    if (power_fail) begin
      nxt_state = brc_pkg::ST_HOLD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= brc_pkg::ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // reset, execution and monitor outputs
  // reset follows the next state, so it moves on the same edge as the sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      device_reset_n <= 1'b0;
    end else begin
      device_reset_n <= !(power_fail || other_rst || holds_reset(nxt_state));
    end
  end

  // execution stops while any other reset source is high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      exec_enable <= 1'b0;
    end else begin
      exec_enable <= nxt_state == brc_pkg::ST_RUN && !other_rst;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      generic_bor_reset <= 1'b0;
    end else begin
      generic_bor_reset <= bor_det || lp_req;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      monitor_enable <= 1'b0;
      monitor_level <= 2'h0;
      monitor_erase_force <= 1'b0;
    end else begin
      monitor_enable <= mon_on;
      monitor_level <= bulk_erase_active ? `BRC_LVL_ERASE : cfg.level;
      monitor_erase_force <= bulk_erase_active;
    end
  end

  // a filtered trip while erasing aborts the erase instead of resetting
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      erase_abort <= 1'b0;
    end else begin
      erase_abort <= bulk_erase_active && trip_ff;
    end
  end

  // register port decode and read port
  assign ctrl_wr = reg_wr && ctrl_hit(reg_addr);
  assign ctrl_rd = reg_rd && ctrl_hit(reg_addr);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= `BRC_RDATA_ZERO;
    end else if (ctrl_rd) begin
      reg_rdata <= ctrl_word(sw_en_ff, ready_ff);
    end else begin
      reg_rdata <= `BRC_RDATA_ZERO;
    end
  end

endmodule // brc_reset_ctrl

// ===== tb/brc_reset_ctrl_asserts.sv
// Purpose: port checks of brc_reset_ctrl
// Assumes: single ref_clk domain
// Notes: bound to every brc_reset_ctrl
`timescale 1ns/1ps
module brc_reset_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire brc_pkg::brc_cfg_t cfg,
  input wire brc_pkg::brc_rst_src_t rst_src,
  input wire logic por_good_raw,
  input wire logic low_power_brownout_raw,
  input wire logic bulk_erase_active,
  input wire logic monitor_enable,
  input wire logic [1:0] monitor_level,
  input wire logic monitor_erase_force,
  input wire logic erase_abort,
  input wire logic generic_bor_reset,
  input wire logic device_reset_n,
  input wire logic exec_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_MODE_ON: assert property ((por_good_raw && cfg.mode == 2'h3)[*4] |-> monitor_enable)
    else $error("monitor off in always-on mode");
  AST_MODE_OFF: assert property ((cfg.mode == 2'h0 && !bulk_erase_active)[*2] |-> !monitor_enable)
    else $error("monitor on in off mode");
  AST_POR: assert property (!por_good_raw[*5] |-> !device_reset_n && !exec_enable)
    else $error("running without power-on good");
  AST_SRC: assert property (rst_src != '0 |=> !device_reset_n)
    else $error("reset source ignored");
  AST_LP: assert property (low_power_brownout_raw[*5] |-> generic_bor_reset)
    else $error("low-power request lost");
  AST_ERASE: assert property (bulk_erase_active[*2] |-> monitor_erase_force && monitor_enable && monitor_level == 2'h0)
    else $error("erase not forcing monitor");
  AST_ABORT: assert property ($rose(erase_abort) |-> device_reset_n)
    else $error("erase trip reset device");
  AST_RD_ZERO: assert property (!(reg_rd && reg_addr == 4'h0) |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RD_PAD: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[6:1] == 6'h00)
    else $error("unused bits nonzero");
  cover property (erase_abort);
  cover property ($rose(exec_enable));
  cover property (reg_rd && reg_addr == 4'h0);
endmodule // brc_reset_ctrl_chk
bind brc_reset_ctrl brc_reset_ctrl_chk chk (.*);

// ===== tb/brc_reset_ctrl_test.sv
// Purpose: directed bench for brc_reset_ctrl
// Assumes: warm-up 20, filter 10, power-up 50 cycles
// Notes: one task per scenario
`timescale 1ns/1ps
module brc_reset_ctrl_test;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic por = 0, below = 0, lp = 0, slp = 0, ers = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd;
  brc_pkg::brc_cfg_t cfg = '0;
  brc_pkg::brc_rst_src_t src = '0;
  logic men, ef, ea, gb, drn, ex;
  logic [1:0] ml;
  int n_fail = 0;
  int n_tests = 0;
  always #2.5 ref_clk = ~ref_clk;
  brc_reset_ctrl #(.WARM_NS(100), .FILT_NS(50), .POWER_UP_TIMER_NS(250)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rd), .cfg(cfg), .rst_src(src), .por_good_raw(por), .bor_below_raw(below),
    .low_power_brownout_raw(lp), .sleep_active(slp), .bulk_erase_active(ers), .monitor_enable(men),
    .monitor_level(ml), .monitor_erase_force(ef), .erase_abort(ea), .generic_bor_reset(gb),
    .device_reset_n(drn), .exec_enable(ex));
  task give_verdict;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wd <= d;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 chk("ctrl", e, rd);
  endtask
  // bounded wait for execution, cycles counted from the call
  task wex(input int lo, input int hi);
    int n;
    n = 0;
    while (ex !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 300) begin
        n_fail++;
        $display("ERROR wait_ex exp 1 got %b", ex);
        give_verdict();
      end
    end
    chk("ex_lo", 1, n >= lo);
    chk("ex_hi", 1, n <= hi);
  endtask
  task boot(input logic [1:0] m, input logic p, input int lo, input int hi);
    logic [1:0] lv;
    lv = m ^ 2'h1;
    @(posedge ref_clk);
    rst_n <= 0;
    por <= 0;
    cfg <= '{m, lv, p};
    cyc(5);
    @(posedge ref_clk);
    rst_n <= 1;
    por <= 1;
    #1 wex(lo, hi);
    chk("level", lv, ml);
  endtask
  task nap(input int lo, input int hi, input logic me);
    @(posedge ref_clk);
    slp <= 1;
    cyc(6);
    chk("sleep_mon", me, men);
    chk("sleep_ex", 0, ex);
    @(posedge ref_clk);
    slp <= 0;
    #1 wex(lo, hi);
  endtask
  task srcs;
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      src <= brc_pkg::brc_rst_src_t'(7'h01 << i);
      cyc(2);
      chk("src_rst", 0, drn);
      @(posedge ref_clk);
      src <= '0;
      #1 wex(1, 8);
    end
  endtask
  task erase_trip;
    @(posedge ref_clk);
    ers <= 1;
    cyc(3);
    chk("ers_lvl", 2'h0, ml);
    chk("ers_frc", 1, ef);
    @(posedge ref_clk);
    below <= 1;
    cyc(30);
    chk("abort", 1, ea);
    chk("no_rst", 1, drn);
    @(posedge ref_clk);
    below <= 0;
    cyc(5);
    @(posedge ref_clk);
    ers <= 0;
    cyc(2);
    chk("ers_end_lvl", cfg.level, ml);
  endtask
  task dips;
    @(posedge ref_clk);
    below <= 1;
    cyc(8);
    @(posedge ref_clk);
    below <= 0;
    cyc(4);
    chk("short_dip", 1, drn);
    @(posedge ref_clk);
    below <= 1;
    cyc(30);
    chk("long_dip", 0, drn);
    chk("bor_gen", 1, gb);
    @(posedge ref_clk);
    below <= 0;
    #1 wex(1, 60);
  endtask
  initial begin
    boot(2'h1, 0, 1, 8);
    rdc(4'h0, 8'h80);
    cyc(25);
    rdc(4'h0, 8'h81);
    rdc(4'h3, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'hfe);
    rdc(4'h0, 8'h81);
    wr(4'h0, 8'h00);
    cyc(3);
    chk("sw_off", 0, men);
    rdc(4'h0, 8'h00);
    nap(0, 4, 0);
    srcs();
    rdc(4'h0, 8'h00);
    @(posedge ref_clk);
    por <= 0;
    cyc(6);
    chk("por_rst", 0, drn);
    rdc(4'h0, 8'h80);
    @(posedge ref_clk);
    por <= 1;
    #1 wex(1, 8);
    boot(2'h1, 1, 50, 80);
    boot(2'h3, 0, 20, 40);
    wr(4'h0, 8'h00);
    cyc(3);
    chk("on_mon", 1, men);
    nap(0, 4, 1);
    erase_trip();
    dips();
    boot(2'h2, 0, 20, 40);
    nap(15, 40, 0);
    boot(2'h0, 0, 1, 8);
    chk("off_mon", 0, men);
    nap(0, 4, 0);
    @(posedge ref_clk);
    lp <= 1;
    cyc(6);
    chk("lp_gen", 1, gb);
    chk("lp_rst", 0, drn);
    @(posedge ref_clk);
    lp <= 0;
    #1 wex(1, 8);
    give_verdict();
  end
endmodule // brc_reset_ctrl_test
